// ### common/nfh_pkg.sv
// package for the nor flash host controller
package nfh_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;

  // word-mode command offsets
  localparam logic [ADDR_W-1:0] WORD_UNLOCK1 = 24'h000555;
  localparam logic [ADDR_W-1:0] WORD_UNLOCK2 = 24'h0002aa;
  // byte-mode command offsets
  localparam logic [ADDR_W-1:0] BYTE_UNLOCK1 = 24'h000aaa;
  localparam logic [ADDR_W-1:0] BYTE_UNLOCK2 = 24'h000555;

  localparam logic [DATA_W-1:0] CMD_UNLOCK1   = 16'h00aa;
  localparam logic [DATA_W-1:0] CMD_UNLOCK2   = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_ID_ENTRY  = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_PROGRAM   = 16'h00a0;
  localparam logic [DATA_W-1:0] CMD_RESET     = 16'h00f0;

  // identification read offsets
  localparam logic [ADDR_W-1:0] ID_MAKER      = 24'h000000;
  localparam logic [ADDR_W-1:0] ID_DEV1       = 24'h000001;
  localparam logic [ADDR_W-1:0] ID_SECURE     = 24'h000003;
  localparam logic [ADDR_W-1:0] ID_DEV2       = 24'h00000e;
  localparam logic [ADDR_W-1:0] ID_DEV3       = 24'h00000f;
  localparam logic [ADDR_W-1:0] ID_SECT_LOCK  = 24'h000002;

  localparam int  DATA_BIT_SEVEN = 7;
  localparam int  TOGGLE_BIT     = 6;
  localparam int  TIMEOUT_BIT    = 5;

  // strobe phase timing, ns at 100 ns clock
  localparam int CLK_NS       = 100;
  localparam int PHASE_NS     = 100;
  localparam int PHASE_CYC    = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PHASE_CYC_1  = (PHASE_CYC < 1) ? 1 : PHASE_CYC;

  typedef enum logic [2:0]
  {
    OP_READ,
    OP_ID_ENTER,
    OP_ID_EXIT,
    OP_PROGRAM,
    OP_RESET_CMD
  } nfh_op_e;

  typedef struct packed
  {
    nfh_op_e             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } nfh_req_s;

  typedef struct packed
  {
    logic                ce_n;
    logic                we_n;
    logic                oe_n;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   dq_out;
    logic                dq_oe;
  } nfh_pins_s;

  typedef struct packed
  {
    logic                done;
    logic                fail;
    logic [DATA_W-1:0]   rdata;
  } nfh_rsp_s;

endpackage

// ### rtl/nfh_bus_cycle.sv
// one asynchronous-strobe bus cycle, read or write, on the flash pins
`timescale 1ns/1ps
module nfh_bus_cycle #(
  parameter int PHASE = nfh_pkg::PHASE_CYC_1
)(
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_ce,
  input  wire logic                        i_start,
  input  wire logic                        i_write,
  input  wire logic [nfh_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [nfh_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic [nfh_pkg::DATA_W-1:0]  i_dq,
  output nfh_pkg::nfh_pins_s               o_pins,
  output logic [nfh_pkg::DATA_W-1:0]       o_rdata,
  output logic                             o_busy,
  output logic                             o_done
);

  initial
  begin
    if (PHASE < 1 || PHASE > 255)
      $error("phase count out of range");
  end

  typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD} nfh_bc_e;

  typedef struct packed
  {
    nfh_bc_e                    st;
    logic [7:0]                 cnt;
    nfh_pkg::nfh_pins_s         pins;
    logic [nfh_pkg::DATA_W-1:0] rdata;
    logic                       done;
  } nfh_bc_s;

  localparam logic [7:0] PHASE_LAST = 8'(PHASE - 1);

  nfh_bc_s r;
  nfh_bc_s next_r;

  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    unique case (r.st)
      BC_IDLE:
      begin
        if (i_start)
        begin
          // address and oe set up before strobes fall
          next_r.pins.addr = i_addr;
          next_r.pins.dq_out = i_wdata;
          next_r.pins.dq_oe = i_write;
          next_r.pins.oe_n = 1'b1;
          next_r.cnt = 8'h00;
          next_r.st = BC_SETUP;
        end
      end
      BC_SETUP:
      begin
        next_r.pins.ce_n = 1'b0;
        next_r.pins.we_n = !r.pins.dq_oe;
        next_r.pins.oe_n = r.pins.dq_oe;
        next_r.st = BC_STROBE;
      end
      BC_STROBE:
      begin
        if (r.cnt == PHASE_LAST)
        begin
          next_r.rdata = r.pins.dq_oe ? r.rdata : i_dq;
          next_r.pins.ce_n = 1'b1;
          next_r.pins.we_n = 1'b1;
          next_r.pins.oe_n = 1'b1;
          next_r.cnt = 8'h00;
          next_r.st = BC_HOLD;
        end
        else
          next_r.cnt = r.cnt + 8'h01;
      end
      BC_HOLD:
      begin
        // data held past the rising strobe edge
        next_r.pins.dq_oe = 1'b0;
        next_r.done = 1'b1;
        next_r.st = BC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      r <= '0;
      r.st <= BC_IDLE;
      r.pins.ce_n <= 1'b1;
      r.pins.we_n <= 1'b1;
      r.pins.oe_n <= 1'b1;
    end
    else if (i_ce)
      r <= next_r;
  end

  assign o_pins  = r.pins;
  assign o_rdata = r.rdata;
  assign o_busy  = (r.st != BC_IDLE);
  assign o_done  = r.done;

endmodule

// ### rtl/nfh_host.sv
// host controller driving a parallel nor flash command interface
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - id entry is aa at 555, 55 at 2aa, 90 at 555.
// - one f0 write at any address leaves id mode.
// - each write holds ce and we low, oe high.
// - program is aa 555, 55 2aa, a0 555, then data at target.
// - hardware reset aborts program; host repeats whole sequence. here reset only returns the host to idle; the requester reissues.
// - host polls until not busy; on timeout error writes reset.
// - host leaves id mode with the reset command.
// - host never issues id entry while programming.
//////////////////////////////////////////////////////////////////////////////
module nfh_host #(
  parameter int POLL_MAX = 4096
)(
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_ce,
  input  wire logic                        i_byte_mode,
  input  wire logic                        i_req_valid,
  input  nfh_pkg::nfh_req_s                i_req,
  output logic                             o_req_ready,
  output nfh_pkg::nfh_rsp_s                o_rsp,
  output nfh_pkg::nfh_pins_s               o_pins,
  input  wire logic [nfh_pkg::DATA_W-1:0]  i_dq
);

  initial
  begin
    if (POLL_MAX < 1 || POLL_MAX > 65535)
      $error("poll limit out of range");
  end

  typedef enum logic [3:0]
  {
    HS_IDLE, HS_SEQ, HS_POLL_A, HS_POLL_B, HS_RECOVER, HS_RESP
  } nfh_hs_e;

  typedef struct packed
  {
    nfh_hs_e                    st;
    nfh_pkg::nfh_req_s          req;
    logic [2:0]                 step;
    logic [15:0]                polls;
    logic [nfh_pkg::DATA_W-1:0] last;
    logic                       fail;
    nfh_pkg::nfh_rsp_s          rsp;
  } nfh_host_s;

  localparam logic [15:0] POLL_LAST = 16'(POLL_MAX - 1);

  nfh_host_s                    r;
  nfh_host_s                    next_r;
  logic                         bc_start;
  logic                         bc_write;
  logic [nfh_pkg::ADDR_W-1:0]   bc_addr;
  logic [nfh_pkg::DATA_W-1:0]   bc_wdata;
  logic [nfh_pkg::DATA_W-1:0]   bc_rdata;
  logic                         bc_busy;
  logic                         bc_done;
  logic [nfh_pkg::ADDR_W-1:0]   ul1;
  logic [nfh_pkg::ADDR_W-1:0]   ul2;
  logic [2:0]                   seq_len;

  nfh_bus_cycle nfh_bus_cycle_i (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_start    (bc_start),
    .i_write    (bc_write),
    .i_addr     (bc_addr),
    .i_wdata    (bc_wdata),
    .i_dq       (i_dq),
    .o_pins     (o_pins),
    .o_rdata    (bc_rdata),
    .o_busy     (bc_busy),
    .o_done     (bc_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // command step table

  always_comb
  begin
    ul1 = i_byte_mode ? nfh_pkg::BYTE_UNLOCK1 : nfh_pkg::WORD_UNLOCK1;
    ul2 = i_byte_mode ? nfh_pkg::BYTE_UNLOCK2 : nfh_pkg::WORD_UNLOCK2;
    bc_write = 1'b1;
    bc_addr  = r.req.addr;
    bc_wdata = r.req.data;
    seq_len  = 3'd1;
    unique case (r.req.op)
      nfh_pkg::OP_READ:
      begin
        bc_write = 1'b0;
      end
      nfh_pkg::OP_ID_EXIT, nfh_pkg::OP_RESET_CMD:
      begin
        bc_wdata = nfh_pkg::CMD_RESET;
      end
      nfh_pkg::OP_ID_ENTER, nfh_pkg::OP_PROGRAM:
      begin
        seq_len = (r.req.op == nfh_pkg::OP_PROGRAM) ? 3'd4 : 3'd3;
        unique case (r.step)
          3'd0:
          begin
            bc_addr  = ul1;
            bc_wdata = nfh_pkg::CMD_UNLOCK1;
          end
          3'd1:
          begin
            bc_addr  = ul2;
            bc_wdata = nfh_pkg::CMD_UNLOCK2;
          end
          3'd2:
          begin
            bc_addr  = ul1;
            bc_wdata = (r.req.op == nfh_pkg::OP_PROGRAM) ?
                       nfh_pkg::CMD_PROGRAM : nfh_pkg::CMD_ID_ENTRY;
          end
          default:
          begin
            bc_addr  = r.req.addr;
            bc_wdata = r.req.data;
          end
        endcase
      end
      default:
      begin
        bc_write = 1'b0;
      end
    endcase
    // status polls are reads at the target, never writes
    if (r.st == HS_POLL_A || r.st == HS_POLL_B)
      bc_write = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer

  assign o_req_ready = (r.st == HS_IDLE);

  always_comb
  begin
    next_r = r;
    next_r.rsp.done = 1'b0;
    bc_start = 1'b0;
    unique case (r.st)
      HS_IDLE:
      begin
        if (i_req_valid)
        begin
          next_r.req   = i_req;
          next_r.step  = 3'd0;
          next_r.polls = 16'h0000;
          next_r.fail  = 1'b0;
          next_r.st    = HS_SEQ;
        end
      end
      HS_SEQ:
      begin
        bc_start = !bc_busy && !bc_done;
        if (bc_done)
        begin
          if (r.req.op == nfh_pkg::OP_READ)
          begin
            next_r.rsp.rdata = i_byte_mode ? {8'h00, bc_rdata[7:0]} : bc_rdata;
            next_r.st = HS_RESP;
          end
          else if (r.step + 3'd1 == seq_len)
          begin
            if (r.req.op == nfh_pkg::OP_PROGRAM)
              next_r.st = HS_POLL_A;
            else
              next_r.st = HS_RESP;
          end
          else
            next_r.step = r.step + 3'd1;
        end
      end
      HS_POLL_A:
      begin
        // toggle polling: two reads compared on bit six
        bc_start = !bc_busy && !bc_done;
        if (bc_done)
        begin
          next_r.last = bc_rdata;
          next_r.st = HS_POLL_B;
        end
      end
      HS_POLL_B:
      begin
        bc_start = !bc_busy && !bc_done;
        if (bc_done)
        begin
          next_r.last = bc_rdata;
          if (bc_rdata[nfh_pkg::TOGGLE_BIT] == r.last[nfh_pkg::TOGGLE_BIT])
          begin
            next_r.rsp.rdata = bc_rdata;
            next_r.st = HS_RESP;
          end
          else if (r.last[nfh_pkg::TIMEOUT_BIT] || r.polls == POLL_LAST)
          begin
            next_r.fail = 1'b1;
            next_r.req.op = nfh_pkg::OP_RESET_CMD;
            next_r.st = HS_RECOVER;
          end
          else
            next_r.polls = r.polls + 16'h0001;
        end
      end
      HS_RECOVER:
      begin
        bc_start = !bc_busy && !bc_done;
        if (bc_done)
          next_r.st = HS_RESP;
      end
      HS_RESP:
      begin
        next_r.rsp.done = 1'b1;
        next_r.rsp.fail = r.fail;
        next_r.st = HS_IDLE;
      end
      default:
      begin
        next_r.st = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      r <= '0;
      r.st <= HS_IDLE;
    end
    else if (i_ce)
      r <= next_r;
  end

  assign o_rsp = r.rsp;

endmodule

// ### tb/nfh_host_checker.sv
// assertions on the nor flash host controller ports
`timescale 1ns/1ps
module nfh_host_checker #(
  parameter int POLL_MAX = 4096
)(
  input wire logic                        i_core_clk,
  input wire logic                        i_rst,
  input wire logic                        i_ce,
  input wire logic                        i_byte_mode,
  input wire logic                        i_req_valid,
  input nfh_pkg::nfh_req_s                i_req,
  input wire logic                        o_req_ready,
  input nfh_pkg::nfh_rsp_s                o_rsp,
  input nfh_pkg::nfh_pins_s               o_pins,
  input wire logic [nfh_pkg::DATA_W-1:0]  i_dq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic tk;
  assign tk = i_req_valid & o_req_ready & i_ce;
  rst_idle_a: assert property (disable iff (1'b0) i_rst |=> o_pins.ce_n && o_pins.we_n
    && o_pins.oe_n && !o_pins.dq_oe && o_req_ready) else $error("pins not idle after reset");
  wr_strobe_a: assert property (!o_pins.we_n |-> !o_pins.ce_n && o_pins.oe_n
    && o_pins.dq_oe) else $error("write strobe with bad ce, oe or drive");
  rd_strobe_a: assert property (!o_pins.oe_n |-> o_pins.we_n && !o_pins.dq_oe)
    else $error("read strobe while driving");
  wr_hold_a: assert property ($fell(o_pins.we_n) |=> $stable(o_pins.addr)
    && $stable(o_pins.dq_out) && o_pins.dq_oe) else $error("write value moved under strobe");
  done_one_a: assert property (o_rsp.done |=> !o_rsp.done)
    else $error("done longer than one cycle");
  busy_a: assert property (tk |=> !o_req_ready) else $error("ready while busy");
  id_seq_a: assert property (tk && i_req.op == nfh_pkg::OP_ID_ENTER && !i_byte_mode
    |-> ##[1:6] ($fell(o_pins.we_n) && o_pins.addr == nfh_pkg::WORD_UNLOCK1
    && o_pins.dq_out == nfh_pkg::CMD_UNLOCK1)) else $error("bad first unlock write");
  byte_seq_a: assert property (tk && i_req.op == nfh_pkg::OP_ID_ENTER && i_byte_mode
    |-> ##[1:6] ($fell(o_pins.we_n) && o_pins.addr == nfh_pkg::BYTE_UNLOCK1))
    else $error("bad byte unlock address");
  prog_seq_a: assert property (tk && i_req.op == nfh_pkg::OP_PROGRAM && !i_byte_mode
    |-> ##[1:30] ($fell(o_pins.we_n) && o_pins.addr == nfh_pkg::WORD_UNLOCK1
    && o_pins.dq_out == nfh_pkg::CMD_PROGRAM)) else $error("no program setup write");
  exit_cmd_a: assert property (tk && i_req.op == nfh_pkg::OP_ID_EXIT
    |-> ##[1:8] ($fell(o_pins.we_n) && o_pins.dq_out == nfh_pkg::CMD_RESET))
    else $error("no exit command write");
endmodule
bind nfh_host nfh_host_checker #(.POLL_MAX(POLL_MAX)) nfh_host_checker_i (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce), .i_byte_mode(i_byte_mode),
  .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
  .o_rsp(o_rsp), .o_pins(o_pins), .i_dq(i_dq));

// ### tb/nfh_flash_model.sv
// behavioural nor flash device facing the host controller
`timescale 1ns/1ps
module nfh_flash_model #(
  parameter int          BUSY_READS = 4,
  parameter logic [15:0] MAKER      = 16'h005a,
  parameter logic [15:0] DEV1       = 16'h1357,
  parameter logic [15:0] DEV2       = 16'h2468,
  parameter logic [15:0] DEV3       = 16'h0a0b,
  parameter logic [15:0] SECURE     = 16'h0019
)(
  input nfh_pkg::nfh_pins_s  i_pins,
  input wire logic           i_byte_mode,
  input wire logic           i_fail_mode,
  output logic [15:0]        o_dq
);
  logic [15:0] mem [16];
  logic [15:0] last;
  logic [15:0] program_write_value;
  logic [23:0] la;
  logic [23:0] program_target_address;
  logic [1:0]  st;
  logic        idm;
  logic        busy;
  logic        tog;
  int          cnt;
  wire logic   wr_n = i_pins.ce_n | i_pins.we_n;
  wire logic   rd_n = i_pins.ce_n | i_pins.oe_n;
  // released bus shows the inverse of the last value
  assign o_dq = rd_n ? ~last : last;
  initial
  begin
    st = 2'd0;
    idm = 1'b0;
    busy = 1'b0;
    tog = 1'b0;
    last = 16'h0000;
    foreach (mem[k]) mem[k] = 16'hffff;
  end
  always @(negedge wr_n) la = i_pins.addr;
  always @(posedge wr_n)
  begin
    if (busy)
    begin
      if (i_fail_mode && i_pins.dq_out == nfh_pkg::CMD_RESET) busy = 1'b0;
    end
    else if (st == 2'd3)
    begin
      program_target_address = la;
      program_write_value = i_pins.dq_out;
      busy = 1'b1;
      cnt = 0;
      st = 2'd0;
    end
    else if (i_pins.dq_out == nfh_pkg::CMD_RESET) {idm, st} = 3'd0;
    else if (la == (i_byte_mode ? 24'h000aaa : 24'h000555)
             && i_pins.dq_out == nfh_pkg::CMD_UNLOCK1) st = 2'd1;
    else if (st == 2'd1 && la == (i_byte_mode ? 24'h000555 : 24'h0002aa)
             && i_pins.dq_out == nfh_pkg::CMD_UNLOCK2) st = 2'd2;
    else if (st == 2'd2 && i_pins.dq_out == nfh_pkg::CMD_ID_ENTRY) {idm, st} = 3'd4;
    else if (st == 2'd2 && i_pins.dq_out == nfh_pkg::CMD_PROGRAM) st = 2'd3;
    else st = 2'd0;
  end
  always @(negedge rd_n)
  begin
    if (busy)
    begin
      tog = ~tog;
      last = {8'h00, ~program_write_value[7], tog, i_fail_mode, 5'h00};
      cnt++;
      if (!i_fail_mode && cnt == BUSY_READS)
      begin
        mem[program_target_address[3:0]] =
          mem[program_target_address[3:0]] & program_write_value;
        busy = 1'b0;
      end
    end
    else if (idm)
      case (i_pins.addr[3:0])
        4'h0: last = MAKER;
        4'h1: last = DEV1;
        4'he: last = DEV2;
        4'hf: last = DEV3;
        4'h2: last = 16'h0001;
        4'h3: last = SECURE;
        default: last = 16'h0000;
      endcase
    else last = mem[i_pins.addr[3:0]];
  end
endmodule

// ### tb/nfh_host_tb.sv
// self-checking bench for the nor flash host controller
`timescale 1ns/1ps
module nfh_host_tb;
  localparam logic [15:0] MK = 16'h005a; // arbitrary
  localparam logic [15:0] D1 = 16'h1357; // arbitrary
  localparam logic [15:0] D2 = 16'h2468; // arbitrary
  localparam logic [15:0] D3 = 16'h0a0b; // arbitrary
  logic               i_core_clk = 1'b0;
  logic               i_rst = 1'b1;
  logic               i_byte_mode = 1'b0;
  logic               i_req_valid = 1'b0;
  logic               fail_mode = 1'b0;
  logic               ce = 1'b1;
  nfh_pkg::nfh_req_s  i_req = '0;
  logic               o_req_ready;
  nfh_pkg::nfh_rsp_s  o_rsp;
  nfh_pkg::nfh_pins_s o_pins;
  logic [15:0]        i_dq;
  int                 err_count = 0;
  int                 check_count = 0;
  int                 cyc = 0;
  nfh_host #(.POLL_MAX(8)) nfh_host_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(ce),
    .i_byte_mode(i_byte_mode), .i_req_valid(i_req_valid), .i_req(i_req),
    .o_req_ready(o_req_ready), .o_rsp(o_rsp), .o_pins(o_pins), .i_dq(i_dq));
  nfh_flash_model #(.MAKER(MK), .DEV1(D1), .DEV2(D2), .DEV3(D3)) nfh_flash_model_i (
    .i_pins(o_pins), .i_byte_mode(i_byte_mode), .i_fail_mode(fail_mode), .o_dq(i_dq));
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do
    begin
      @(negedge i_core_clk);
      n++;
    end
    while (o_rsp.done !== 1'b1 && n < 400);
    if (o_rsp.done !== 1'b1)
    begin
      err_count++;
      $display("[ERR] done expected 1 seen 0");
      print_verdict();
    end
  endtask
  task automatic op(input nfh_pkg::nfh_op_e o, input logic [23:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_req_valid <= 1'b1;
    i_req <= '{op: o, addr: a, data: d};
    @(posedge i_core_clk);
    i_req_valid <= 1'b0;
    wait_done();
  endtask
  ////////////////////////////////////////
  task automatic t_id();
    logic [23:0] a [7] = '{24'h0, 24'h1, 24'he, 24'hf, 24'h3, 24'h010002, 24'h0};
    logic [15:0] e [7] = '{MK, D1, D2, D3, 16'h0019, 16'h0001, MK};
    op(nfh_pkg::OP_ID_ENTER, 24'h0, 16'h0);
    for (int k = 0; k < 14; k++)
    begin
      op(nfh_pkg::OP_READ, a[k % 7], 16'h0);
      chk("id read", o_rsp.rdata, e[k % 7]);
    end
    op(nfh_pkg::OP_ID_EXIT, 24'h000123, 16'h0);
    op(nfh_pkg::OP_READ, 24'h0, 16'h0);
    chk("read after exit", o_rsp.rdata, 16'hffff);
  endtask
  task automatic t_prog();
    op(nfh_pkg::OP_PROGRAM, 24'h5, 16'h00f0);
    chk("prog fail", {15'h0, o_rsp.fail}, 16'h0);
    op(nfh_pkg::OP_READ, 24'h5, 16'h0);
    chk("prog read", o_rsp.rdata, 16'h00f0);
    op(nfh_pkg::OP_PROGRAM, 24'h5, 16'h0f3c);
    op(nfh_pkg::OP_READ, 24'h5, 16'h0);
    chk("reprog read", o_rsp.rdata, 16'h0030);
    op(nfh_pkg::OP_PROGRAM, 24'hb, 16'h1234);
    op(nfh_pkg::OP_READ, 24'hb, 16'h0);
    chk("second word", o_rsp.rdata, 16'h1234);
  endtask
  task automatic t_freeze();
    @(posedge i_core_clk);
    i_req_valid <= 1'b1;
    i_req <= '{op: nfh_pkg::OP_READ, addr: 24'h5, data: 16'h0};
    @(posedge i_core_clk);
    i_req_valid <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    ce <= 1'b0;
    repeat (20) @(posedge i_core_clk);
    @(negedge i_core_clk);
    chk("frozen strobes", {13'h0, o_pins.ce_n, o_pins.we_n, o_pins.oe_n}, 16'h0002);
    chk("frozen done", {15'h0, o_rsp.done}, 16'h0);
    chk("frozen addr", o_pins.addr[15:0], 16'h0005);
    @(posedge i_core_clk);
    ce <= 1'b1;
    wait_done();
    chk("read after freeze", o_rsp.rdata, 16'h0030);
  endtask
  task automatic t_byte();
    @(posedge i_core_clk);
    i_byte_mode <= 1'b1;
    op(nfh_pkg::OP_ID_ENTER, 24'h0, 16'h0);
    op(nfh_pkg::OP_READ, 24'h1, 16'h0);
    chk("byte id", o_rsp.rdata, {8'h00, D1[7:0]});
    op(nfh_pkg::OP_ID_EXIT, 24'h0, 16'h0);
    op(nfh_pkg::OP_PROGRAM, 24'h6, 16'h00ab);
    op(nfh_pkg::OP_READ, 24'h6, 16'h0);
    chk("byte prog", o_rsp.rdata, 16'h00ab);
    @(posedge i_core_clk);
    i_byte_mode <= 1'b0;
  endtask
  task automatic t_fail();
    @(posedge i_core_clk);
    fail_mode <= 1'b1;
    op(nfh_pkg::OP_PROGRAM, 24'h7, 16'h0000);
    chk("fail flag", {15'h0, o_rsp.fail}, 16'h1);
    @(posedge i_core_clk);
    fail_mode <= 1'b0;
    op(nfh_pkg::OP_READ, 24'h7, 16'h0);
    chk("read after fail", o_rsp.rdata, 16'hffff);
  endtask
  task automatic t_abort();
    @(posedge i_core_clk);
    i_req_valid <= 1'b1;
    i_req <= '{op: nfh_pkg::OP_PROGRAM, addr: 24'h3, data: 16'h0033};
    @(posedge i_core_clk);
    i_req_valid <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    i_rst <= 1'b1;
    @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(negedge i_core_clk);
    chk("abort strobe", {15'h0, o_pins.ce_n & o_pins.we_n}, 16'h1);
    op(nfh_pkg::OP_PROGRAM, 24'h3, 16'h0033);
    op(nfh_pkg::OP_READ, 24'h3, 16'h0);
    chk("repeat prog", o_rsp.rdata, 16'h0033);
  endtask
  ////////////////////////////////////////
  initial
  begin
    forever #50 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (3) @(posedge i_core_clk);
    i_rst <= 1'b0;
    t_id();
    t_prog();
    t_freeze();
    t_byte();
    t_fail();
    t_abort();
    print_verdict();
  end
endmodule
